// *** verilog/pp_map.svh ***
// Purpose: Address map, field positions, codes and reset values of the extended control block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes:   Definitions only; included by the event unit, the top module and the bench.
`ifndef PP_MAP_SVH
`define PP_MAP_SVH

// Register indices and their byte addresses (index times four).
`define PP_IDX_ECR      16'h0002
`define PP_IDX_LEVEL    16'h0004
`define PP_IDX_STATUS   16'h0005
`define PP_IDX_MASK     16'h0006
`define PP_IDX_CFGA     16'h0400
`define PP_IDX_CFGB     16'h0401
`define PP_ADDR_W       16

// Extended control fields.
`define PP_ECR_MODE_HI  7
`define PP_ECR_MODE_LO  5
`define PP_ECR_FDIS     4
`define PP_ECR_DMA_REQUEST_ENABLE    3
`define PP_ECR_SVC      2
`define PP_ECR_FULL     1
`define PP_ECR_EMPTY    0

// Mode codes.
`define PP_MODE_SPP     3'h0
`define PP_MODE_PS2     3'h1
`define PP_MODE_FIFO    3'h2
`define PP_MODE_ECP     3'h3
`define PP_MODE_EPP     3'h4
`define PP_MODE_TEST    3'h6
`define PP_MODE_CFG     3'h7

// Level register fields.
`define PP_LVL_WR_LO    0
`define PP_LVL_RD_LO    8

// Interrupt status and mask bit positions.
`define PP_INT_FAULT    0
`define PP_INT_SVC      1
`define PP_INT_N        2

// Reset values.
`define PP_RST_MODE     3'h0
`define PP_RST_SVC      1'b1
`define PP_RST_LEVEL    8'h08
`define PP_RST_CFG      8'h00

// AXI responses.
`define PP_RESP_OKAY    2'h0
`define PP_RESP_SLVERR  2'h2

`endif

// *** verilog/pp_pkg.sv ***
// Purpose: Types shared by the extended control block and its event unit.
// Assumes: Constants come from pp_map.svh.
// Notes:   Nothing here is imported; users write pp_pkg::name.
package pp_pkg;

   // Register selected by one bus address.
   typedef enum logic [2:0] {
      PP_SEL_NONE,
      PP_SEL_ECR,
      PP_SEL_LEVEL,
      PP_SEL_STATUS,
      PP_SEL_MASK,
      PP_SEL_CFGA,
      PP_SEL_CFGB
   } pp_sel_e;

   typedef logic [2:0] pp_mode_t;

   // Whole state of the top module.
   typedef struct packed {
      logic        aw_got;
      logic [15:0] aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      pp_mode_t    mode;
      logic        fault_dis;
      logic        dma_en;
      logic        svc_mask;
      logic [7:0]  write_level;
      logic [7:0]  read_level;
      logic [1:0]  int_status;
      logic [1:0]  int_mask;
      logic        irq;
      logic [7:0]  cfg_a;
      logic [7:0]  cfg_b;
      logic        dma_request;
      logic        port_tx_en;
      logic        fifo_clear;
   } pp_ctl_s;

   // Whole state of the event unit.
   typedef struct packed {
      logic fault_prev;
   } pp_evt_s;

endpackage

// *** verilog/pp_evt_if.sv ***
// Purpose: Carries control bits to the event unit and its events back.
// Assumes: One clock domain.
// Notes:   The top module drives ctl, the event unit drives evt.
`timescale 1ns/10ps
interface pp_evt_if;
   pp_pkg::pp_mode_t mode;
   logic             fault_dis;
   logic             dma_en;
   logic             svc_mask;
   logic             direction;
   logic [7:0]       write_level;
   logic [7:0]       read_level;
   logic [7:0]       free_cnt;
   logic [7:0]       valid_cnt;
   logic             dma_active;
   logic             dma_tc;
   logic             fault_n;
   logic             fault_event;
   logic             service_event;

   modport ctl (output mode, fault_dis, dma_en, svc_mask, direction, write_level, read_level,
                output free_cnt, valid_cnt, dma_active, dma_tc, fault_n,
                input fault_event, service_event);
   modport evt (input mode, fault_dis, dma_en, svc_mask, direction, write_level, read_level,
                input free_cnt, valid_cnt, dma_active, dma_tc, fault_n,
                output fault_event, service_event);
endinterface

// *** verilog/pp_evt.sv ***
// Purpose: Detects the fault edge and the three service conditions.
// Assumes: Peripheral fault input is synchronous to aclk.
// Notes:   Events are single-cycle pulses towards the top module.
`timescale 1ns/10ps
`include "pp_map.svh"
module pp_evt (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Link to the top module.
   pp_evt_if.evt    ev
);

   pp_pkg::pp_evt_s ev_r;
   pp_pkg::pp_evt_s ev_nxt;
   logic            level_hit;

   // Fault history; idle high so release from reset gives no false edge.
   always_comb begin
      ev_nxt = ev_r;
      ev_nxt.fault_prev = ev.fault_n;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_r.fault_prev <= 1'b1;
      end else begin
         ev_r <= ev_nxt;
      end
   end

   // Falling edge only counts in ECP mode with the disable bit clear.
   assign ev.fault_event = ev_r.fault_prev & ~ev.fault_n & ~ev.fault_dis
                           & (ev.mode == `PP_MODE_ECP);

   // Threshold compare depends on direction: free room forward, waiting data reverse.
   assign level_hit = ev.direction ? (ev.valid_cnt >= ev.read_level)
                                   : (ev.free_cnt >= ev.write_level);

   // A set mask blocks every service event, so it fires only once per re-enable.
   assign ev.service_event = ~ev.svc_mask
                             & (ev.dma_en ? (ev.dma_active & ev.dma_tc)
                                          : level_hit);

endmodule

// *** verilog/pp_ext_ctrl.sv ***
// Purpose: Extended control register of a FIFO parallel port, with interrupts, on AXI4-Lite.
// Assumes: All inputs synchronous to aclk; FIFO counts and DMA status come from outside.
// Notes:   Configuration registers only answer while the mode field is configuration mode.
//
// Contract
// - Three-bit read/write mode field in bits 7..5 selects the port mode.
// - Test mode lets the FIFO be written and read but never transmitted.
// - Configuration mode maps config_reg_a and config_reg_b at 0x400 and 0x401.
// - With fault_intr_disable low, each falling fault edge raises an interrupt; the code counts such edges only while the mode field is ECP mode.
// - With fault_intr_disable high, fault edges raise no interrupt.
// - A serviced condition with service_interrupt_mask low sets that bit by hardware.
// - DMA enabled and running: terminal count sets service_interrupt_mask.
// - DMA off, forward: free bytes at or above write_level sets the mask.
// - DMA off, reverse: valid bytes at or above read_level sets the mask.
// - While service_interrupt_mask is high, DMA requests and service interrupts stay off.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "pp_map.svh"
module pp_ext_ctrl (
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write address channel.
   input  wire logic [`PP_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [`PP_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Port and FIFO status.
   input  wire logic                  peripheral_fault_n,
   input  wire logic                  port_direction,
   input  wire logic [7:0]            fifo_free_count,
   input  wire logic [7:0]            fifo_valid_count,
   input  wire logic                  fifo_full,
   input  wire logic                  fifo_empty,
   input  wire logic                  fifo_dma_need,
   // DMA controller status.
   input  wire logic                  dma_active,
   input  wire logic                  dma_terminal_count,
   // Control outputs.
   output logic [2:0]                 port_mode,
   output logic                       port_tx_enable,
   output logic                       fifo_clear,
   output logic                       dma_request,
   output logic [7:0]                 config_reg_a,
   output logic [7:0]                 config_reg_b,
   // Interrupt.
   output logic                       irq
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // State, reset value and decode.

   localparam pp_pkg::pp_ctl_s PP_CTL_RST = '{
      awready     : 1'b1,
      wready      : 1'b1,
      arready     : 1'b1,
      mode        : `PP_RST_MODE,
      svc_mask    : `PP_RST_SVC,
      write_level : `PP_RST_LEVEL,
      read_level  : `PP_RST_LEVEL,
      cfg_a       : `PP_RST_CFG,
      cfg_b       : `PP_RST_CFG,
      fifo_clear  : 1'b1,
      default     : '0
   };

   pp_pkg::pp_ctl_s st_r;
   pp_pkg::pp_ctl_s st_nxt;
   pp_evt_if        evl ();

   // Map a byte address to a register; configuration words exist only in configuration mode.
   function automatic pp_pkg::pp_sel_e pp_decode(input logic [`PP_ADDR_W-1:0] addr,
                                                 input pp_pkg::pp_mode_t      mode);
      pp_pkg::pp_sel_e sel;
      sel = pp_pkg::PP_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case ({2'h0, addr[`PP_ADDR_W-1:2]})
            `PP_IDX_ECR:    sel = pp_pkg::PP_SEL_ECR;
            `PP_IDX_LEVEL:  sel = pp_pkg::PP_SEL_LEVEL;
            `PP_IDX_STATUS: sel = pp_pkg::PP_SEL_STATUS;
            `PP_IDX_MASK:   sel = pp_pkg::PP_SEL_MASK;
            `PP_IDX_CFGA:   sel = (mode == `PP_MODE_CFG) ? pp_pkg::PP_SEL_CFGA : pp_pkg::PP_SEL_NONE;
            `PP_IDX_CFGB:   sel = (mode == `PP_MODE_CFG) ? pp_pkg::PP_SEL_CFGB : pp_pkg::PP_SEL_NONE;
            default:        sel = pp_pkg::PP_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // Assemble the extended control byte; the two low bits are live FIFO flags.
   function automatic logic [7:0] pp_ecr_byte(input pp_pkg::pp_ctl_s s,
                                              input logic            full,
                                              input logic            empty);
      logic [7:0] b;
      b = 8'h00;
      b[`PP_ECR_MODE_HI:`PP_ECR_MODE_LO] = s.mode;
      b[`PP_ECR_FDIS]  = s.fault_dis;
      b[`PP_ECR_DMA_REQUEST_ENABLE] = s.dma_en;
      b[`PP_ECR_SVC]   = s.svc_mask;
      b[`PP_ECR_FULL]  = full;
      b[`PP_ECR_EMPTY] = empty;
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Event unit.

   // Control bits go out from the registers, so events see the value software last wrote.
   assign evl.mode        = st_r.mode;
   assign evl.fault_dis   = st_r.fault_dis;
   assign evl.dma_en      = st_r.dma_en;
   assign evl.svc_mask    = st_r.svc_mask;
   assign evl.direction   = port_direction;
   assign evl.write_level = st_r.write_level;
   assign evl.read_level  = st_r.read_level;
   assign evl.free_cnt    = fifo_free_count;
   assign evl.valid_cnt   = fifo_valid_count;
   assign evl.dma_active  = dma_active;
   assign evl.dma_tc      = dma_terminal_count;
   assign evl.fault_n     = peripheral_fault_n;

   pp_evt u_evt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ev      (evl.evt)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   // One write and one read are handled at a time; the write commits once both halves are in.
   always_comb begin
      pp_pkg::pp_sel_e wsel;
      pp_pkg::pp_sel_e rsel;
      logic            wdo;
      logic [1:0]      events;
      logic [1:0]      w1c;
      logic [31:0]     rd;
      wsel   = pp_pkg::PP_SEL_NONE;
      rsel   = pp_pkg::PP_SEL_NONE;
      wdo    = 1'b0;
      events = 2'h0;
      w1c    = 2'h0;
      rd     = 32'h0000_0000;
      st_nxt = st_r;

      // Response channels drop once the master has taken them.
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // Capture address and data in either order.
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end

      // Commit a complete write only when no earlier response is still waiting.
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         wdo           = 1'b1;
         wsel          = pp_decode(st_r.aw_addr, st_r.mode);
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = (wsel == pp_pkg::PP_SEL_NONE) ? `PP_RESP_SLVERR : `PP_RESP_OKAY;
      end

      // Register writes; byte lane 0 holds every 8-bit register except the read threshold.
      if (wdo && st_r.w_strb[0]) begin
         case (wsel)
            pp_pkg::PP_SEL_ECR: begin
               st_nxt.mode      = st_r.w_data[`PP_ECR_MODE_HI:`PP_ECR_MODE_LO];
               st_nxt.fault_dis = st_r.w_data[`PP_ECR_FDIS];
               st_nxt.dma_en    = st_r.w_data[`PP_ECR_DMA_REQUEST_ENABLE];
               st_nxt.svc_mask  = st_r.w_data[`PP_ECR_SVC];
            end
            pp_pkg::PP_SEL_LEVEL: begin
               st_nxt.write_level = st_r.w_data[`PP_LVL_WR_LO+:8];
            end
            pp_pkg::PP_SEL_STATUS: begin
               w1c = st_r.w_data[`PP_INT_N-1:0];
            end
            pp_pkg::PP_SEL_MASK: begin
               st_nxt.int_mask = st_r.w_data[`PP_INT_N-1:0];
            end
            pp_pkg::PP_SEL_CFGA: begin
               st_nxt.cfg_a = st_r.w_data[7:0];
            end
            pp_pkg::PP_SEL_CFGB: begin
               st_nxt.cfg_b = st_r.w_data[7:0];
            end
            default: begin
            end
         endcase
      end
      // The read threshold sits in lane 1.
      if (wdo && st_r.w_strb[1] && (wsel == pp_pkg::PP_SEL_LEVEL)) begin
         st_nxt.read_level = st_r.w_data[`PP_LVL_RD_LO+:8];
      end

      // Hardware set of the service mask wins over a software clear in the same cycle.
      if (evl.service_event) begin
         st_nxt.svc_mask = 1'b1;
      end

      // Sticky status: events win over write-one-to-clear.
      events[`PP_INT_FAULT] = evl.fault_event;
      events[`PP_INT_SVC]   = evl.service_event;
      for (int i = 0; i < `PP_INT_N; i++) begin
         st_nxt.int_status[i] = events[i] | (st_r.int_status[i] & ~w1c[i]);
      end

      // Reads answer from the present register values.
      if (s_axi_arvalid && st_r.arready) begin
         rsel = pp_decode(s_axi_araddr, st_r.mode);
         case (rsel)
            pp_pkg::PP_SEL_ECR:    rd[7:0] = pp_ecr_byte(st_r, fifo_full, fifo_empty);
            pp_pkg::PP_SEL_LEVEL:  rd[15:0] = {st_r.read_level, st_r.write_level};
            pp_pkg::PP_SEL_STATUS: rd[`PP_INT_N-1:0] = st_r.int_status;
            pp_pkg::PP_SEL_MASK:   rd[`PP_INT_N-1:0] = st_r.int_mask;
            pp_pkg::PP_SEL_CFGA:   rd[7:0] = st_r.cfg_a;
            pp_pkg::PP_SEL_CFGB:   rd[7:0] = st_r.cfg_b;
            default:               rd = 32'h0000_0000;
         endcase
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd;
         st_nxt.rresp  = (rsel == pp_pkg::PP_SEL_NONE) ? `PP_RESP_SLVERR : `PP_RESP_OKAY;
      end

      // Ready flags are registered; each channel pauses while its item or answer is pending.
      st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;

      // Port outputs follow the next mode so they change together with the field.
      st_nxt.port_tx_en = (st_nxt.mode == `PP_MODE_FIFO) || (st_nxt.mode == `PP_MODE_ECP);
      st_nxt.fifo_clear = (st_nxt.mode == `PP_MODE_SPP);

      // Requests need the enable bit, a clear mask and a FIFO mode; test mode drains by software.
      st_nxt.dma_request = st_nxt.dma_en
                           & ~st_nxt.svc_mask
                           & fifo_dma_need
                           & st_nxt.port_tx_en;

      // One level output built from the next status, so it rises with the status bit.
      st_nxt.irq = |(st_nxt.int_status & st_nxt.int_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= PP_CTL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register.

   assign s_axi_awready  = st_r.awready;
   assign s_axi_wready   = st_r.wready;
   assign s_axi_bvalid   = st_r.bvalid;
   assign s_axi_bresp    = st_r.bresp;
   assign s_axi_arready  = st_r.arready;
   assign s_axi_rvalid   = st_r.rvalid;
   assign s_axi_rresp    = st_r.rresp;
   assign s_axi_rdata    = st_r.rdata;
   assign port_mode      = st_r.mode;
   assign port_tx_enable = st_r.port_tx_en;
   assign fifo_clear     = st_r.fifo_clear;
   assign dma_request    = st_r.dma_request;
   assign config_reg_a   = st_r.cfg_a;
   assign config_reg_b   = st_r.cfg_b;
   assign irq            = st_r.irq;

endmodule

// *** bench/pp_ext_ctrl_props.sv ***
// Purpose: Concurrent checks on the ports of the extended control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to pp_ext_ctrl below the module.
`timescale 1ns/10ps
module pp_ext_ctrl_props (
   // Clock and reset.
   input logic        aclk,
   input logic        aresetn,
   // Register bus handshakes.
   input logic        s_axi_awready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   // Port control.
   input logic        fifo_dma_need,
   input logic [2:0]  port_mode,
   input logic        port_tx_enable,
   input logic        fifo_clear,
   input logic        dma_request,
   input logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////
   // Mode decoding; test mode must never drive the port.
   tx_test_off_a: assert property (port_mode == 3'h6 |-> !port_tx_enable) else $error("tx in test mode");
   tx_mode_a: assert property (port_tx_enable |-> port_mode inside {3'h2, 3'h3}) else $error("tx in bad mode");
   clr_spp_a: assert property (fifo_clear == (port_mode == 3'h0)) else $error("fifo clear wrong");
   dreq_mode_a: assert property (dma_request |-> port_mode inside {3'h2, 3'h3}) else $error("dma req bad mode");
   dreq_need_a: assert property (dma_request |-> $past(fifo_dma_need)) else $error("dma req without need");
   // Bus answers stand until taken, and a read answers one cycle later.
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken early");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read latency wrong");
   // Main scenarios.
   wr_c: cover property (s_axi_bvalid && s_axi_bready);
   rd_c: cover property (s_axi_rvalid && s_axi_rready);
   irq_c: cover property ($rose(irq));
   dreq_c: cover property ($rose(dma_request));
endmodule
////////////////////////////////////////////////////////////
bind pp_ext_ctrl pp_ext_ctrl_props chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .fifo_dma_need,
   .port_mode, .port_tx_enable, .fifo_clear, .dma_request, .irq);

// *** bench/pp_periph_model.sv ***
// Purpose: Peripheral on the port that reports faults on its fault line.
// Assumes: Requests come from the bench on aclk.
// Notes:   The line is pulled up, so it reads high whenever released.
`timescale 1ns/10ps
module pp_periph_model #(parameter int HOLD = 3) (
   // Clock.
   input  logic aclk,
   // Bench request to report a fault.
   input  logic fault_req,
   // Fault line, active low.
   output logic peripheral_fault_n
);
   int cnt = 0;
   // Hold the line low a few cycles so the edge is seen clearly.
   always @(posedge aclk) begin
      if (fault_req) cnt <= HOLD;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign peripheral_fault_n = (cnt == 0);
endmodule

// *** bench/pp_ext_ctrl_tb.sv ***
// Purpose: Self-checking bench for the extended control block.
// Assumes: Bus answers come within 40 cycles.
// Notes:   Random values come from a fixed seed.
`timescale 1ns/10ps
`include "pp_map.svh"
module pp_ext_ctrl_tb;
   localparam logic [15:0] A_ECR = `PP_IDX_ECR << 2, A_LVL = `PP_IDX_LEVEL << 2, A_STS = `PP_IDX_STATUS << 2;
   localparam logic [15:0] A_MSK = `PP_IDX_MASK << 2, A_CFA = `PP_IDX_CFGA << 2, A_CFB = `PP_IDX_CFGB << 2;
   logic        aclk = 0, aresetn = 0, fault_req = 0, peripheral_fault_n;
   logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        port_direction = 0, fifo_full = 0, fifo_empty = 1, fifo_dma_need = 0;
   logic        dma_active = 0, dma_terminal_count = 0, port_tx_enable, fifo_clear, dma_request, irq;
   logic [7:0]  fifo_free_count = '0, fifo_valid_count = '0, config_reg_a, config_reg_b;
   logic [2:0]  port_mode;
   int          n_errors = 0, total_checks = 0;
   always #5 aclk = ~aclk;
   pp_periph_model per_u (.aclk, .fault_req, .peripheral_fault_n);
   pp_ext_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .peripheral_fault_n, .port_direction, .fifo_free_count, .fifo_valid_count,
      .fifo_full, .fifo_empty, .fifo_dma_need, .dma_active, .dma_terminal_count, .port_mode,
      .port_tx_enable, .fifo_clear, .dma_request, .config_reg_a, .config_reg_b, .irq);
   ////////////////////////////////////////////////////////////
   // Verdict and comparison.
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus cycles; ready for the answer is raised late so it stands a cycle.
   task automatic wc(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         end_sim();
      end
      chk("bresp", s_axi_bresp, er);
   endtask
   task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         end_sim();
      end
      chk(nm, s_axi_rdata, ed);
      chk("rresp", s_axi_rresp, er);
   endtask
   // Expected control word; low bits mirror the FIFO flags.
   function automatic logic [31:0] extended_control(input logic [2:0] m, input logic f, input logic de, input logic s);
      return {24'h0, m, f, de, s, fifo_full, fifo_empty};
   endfunction
   ////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [31:0] d;
      logic [7:0]  lv;
      int          m;
      void'($urandom(78287));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      fifo_full <= 1'($urandom);
      @(posedge aclk);
      rc("ecr_rst", A_ECR, extended_control(3'h0, 0, 0, 1), 2'h0);
      rc("lvl_rst", A_LVL, 32'h0808, 2'h0);
      rc("unmapped", 16'h00fc, 32'h0, `PP_RESP_SLVERR);
      repeat (6) begin
         d = $urandom & 32'hffff;
         wc(A_LVL, d, 2'h0);
         rc("level", A_LVL, d, 2'h0);
      end
      for (m = 0; m < 8; m++) begin
         if (m == 5) continue;
         lv = 8'($urandom);
         wc(A_ECR, extended_control(3'(m), 0, 0, 1), 2'h0);
         chk("mode", port_mode, m);
         chk("tx_en", port_tx_enable, (m == 2 || m == 3));
         rc("ecr_mode", A_ECR, extended_control(3'(m), 0, 0, 1), 2'h0);
         wc(A_CFA, lv, (m == 7) ? `PP_RESP_OKAY : `PP_RESP_SLVERR);
         rc("cfg_b", A_CFB, 32'h0, (m == 7) ? `PP_RESP_OKAY : `PP_RESP_SLVERR);
         if (m == 7) chk("cfg_pins", {config_reg_b, config_reg_a}, {8'h0, lv});
      end
      // Fault edge with the interrupt enabled, then disabled.
      wc(A_MSK, 32'h3, 2'h0);
      for (m = 0; m < 2; m++) begin
         wc(A_ECR, extended_control(3'h3, m[0], 0, 1), 2'h0);
         fault_req <= 1'b1;
         @(posedge aclk);
         fault_req <= 1'b0;
         repeat (5) @(posedge aclk);
         chk("fault_irq", irq, (m == 0));
         rc("fault_sts", A_STS, (m == 0), 2'h0);
         wc(A_STS, 32'h3, 2'h0);
      end
      // Service thresholds in both directions, hitting the level exactly.
      for (m = 0; m < 2; m++) begin
         lv = 8'($urandom_range(200, 1));
         wc(A_LVL, {16'h0, lv, lv}, 2'h0);
         port_direction <= m[0];
         fifo_free_count <= lv - 8'h1;
         fifo_valid_count <= lv - 8'h1;
         wc(A_ECR, extended_control(3'h2, 0, 0, 0), 2'h0);
         rc("svc_below", A_ECR, extended_control(3'h2, 0, 0, 0), 2'h0);
         fifo_free_count <= m ? 8'h0 : lv;
         fifo_valid_count <= m ? lv : 8'h0;
         repeat (3) @(posedge aclk);
         rc("svc_set", A_ECR, extended_control(3'h2, 0, 0, 1), 2'h0);
         rc("svc_sts", A_STS, 32'h2, 2'h0);
         chk("svc_irq", irq, 1);
         wc(A_STS, 32'h3, 2'h0);
         @(posedge aclk);
         chk("irq_clr", irq, 0);
      end
      // DMA request gating and terminal count.
      fifo_valid_count <= 8'h0;
      fifo_dma_need <= 1'b1;
      dma_active <= 1'b1;
      wc(A_ECR, extended_control(3'h2, 0, 0, 0), 2'h0);
      @(posedge aclk);
      chk("dreq_off", dma_request, 0);
      wc(A_ECR, extended_control(3'h2, 0, 1, 0), 2'h0);
      @(posedge aclk);
      chk("dreq_on", dma_request, 1);
      dma_terminal_count <= 1'b1;
      @(posedge aclk);
      dma_terminal_count <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("dreq_svc", dma_request, 0);
      rc("svc_tc", A_ECR, extended_control(3'h2, 0, 1, 1), 2'h0);
      wc(A_ECR, extended_control(3'h6, 0, 1, 0), 2'h0);
      @(posedge aclk);
      chk("dreq_test", dma_request, 0);
      end_sim();
   end
endmodule
